// ==== hdl/ufc_defs.vh ====
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH
// serial modes held in the two mode bits
`define UFC_MODE_SHIFT    2'h0
`define UFC_MODE_UART8    2'h1
`define UFC_MODE_UART9F   2'h2
`define UFC_MODE_UART9V   2'h3
// serial control bit positions
`define UFC_SC_BIT_FE_M0  7
`define UFC_SC_BIT_M1     6
`define UFC_SC_BIT_MP     5
`define UFC_SC_BIT_REN    4
`define UFC_SC_BIT_TB8    3
`define UFC_SC_BIT_RB8    2
`define UFC_SC_BIT_TI     1
`define UFC_SC_BIT_RI     0
// power control bit position of frame error select
`define UFC_PC_BIT_FES    6
// reset values
`define UFC_RST_ADDR      8'h00
`define UFC_RST_MASK      8'h00
`define UFC_RST_SERIAL_CONTROL_REG      8'h00
// receive oversampling per bit
`define UFC_OVS           16
`define UFC_OVS_MID       4'h7
`define UFC_OVS_LAST      4'hF
// fifo shape
`define UFC_FIFO_W        9
`define UFC_FIFO_D        8
`define UFC_FIFO_AW       3
`endif

// ==== hdl/ufc_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// small synchronous fifo
// ****************************************
module ufc_fifo #(
  parameter W  = 9,
  parameter D  = 8,
  parameter AW = 3
) (
  // clock and reset
  input  wire          clock_i,
  input  wire          reset_n_i,
  // write side
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  // read side
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o
);
  reg  [W-1:0]  mem_q [0:D-1];   // storage
  reg  [AW-1:0] wr_q;            // write pointer
  reg  [AW-1:0] rd_q;            // read pointer
  reg  [AW:0]   cnt_q;           // fill level
  wire          push;
  wire          pop;

  assign in_ready_o  = (cnt_q != D[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage write, no reset needed
  always @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and level
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/ufc_rx.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defs.vh"
// Operation
// - three async modes, duplex, separate rates
// - stop check when select set, and in mode 1 filtering
// - bad stop bit sets frame error
// - frame error sticky until software clear
// - checking moves done flag to stop
// - filtering on exactly when multiproc set in an async mode
// - address frames need match for done
// - mode 1: stop is ninth bit
// - accept individual or broadcast match
// - multiproc ignored in shift mode
// - mask zero bits are don't-care
// - broadcast is address OR mask
// - address and mask reset to zero
// - bit 7 is error or mode bit
module ufc_rx (
  // clock and reset
  input  wire        clock_i,
  input  wire        reset_n_i,
  // serial line and receive sample tick (16x bit rate)
  input  wire        rxd_i,
  input  wire        rx_tick_i,
  // software writes
  input  wire        serial_control_reg_wr_i,
  input  wire [7:0]  serial_control_reg_wdata_i,
  input  wire        power_control_reg_wr_i,
  input  wire [7:0]  power_control_reg_wdata_i,
  input  wire        addr_wr_i,
  input  wire        mask_wr_i,
  input  wire [7:0]  reg_wdata_i,
  // software view
  output wire [7:0]  serial_control_reg_o,
  output wire [7:0]  power_control_reg_o,
  output reg  [7:0]  node_address_byte_o,
  output reg  [7:0]  node_address_mask_o,
  output wire        frame_error_flag_o,
  output wire        receive_done_flag_o,
  // received data stream
  output wire        rx_valid_o,
  input  wire        rx_ready_i,
  output wire [8:0]  rx_data_o
);
  // ****************************************
  // state and register declarations
  // ****************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA  = 2'h2;
  localparam ST_STOP  = 2'h3;

  reg  [2:0] sync_q;          // pin synchroniser
  reg        line_q;          // filtered line level
  reg  [1:0] state_q;         // receive state
  reg  [3:0] ovs_q;           // oversample counter
  reg  [3:0] bit_q;           // data bit index
  reg  [8:0] shift_q;         // received bits, lsb first
  reg        mode0_q;         // mode bit zero (shared bit 7)
  reg        mode1_q;         // mode bit one
  reg        mp_q;            // multiproc enable
  reg        ren_q;           // receive enable
  reg        tb8_q;           // transmit ninth bit
  reg        rb8_q;           // received ninth bit
  reg        ti_q;            // transmit flag, software owned here
  reg        ri_q;            // receive done flag
  reg        fe_q;            // frame error flag
  reg  [7:0] power_control_reg_q;          // power control bits
  reg        push_q;          // fifo push request
  reg  [8:0] push_data_q;     // fifo push data
  wire [1:0] mode;
  wire       fes;
  wire       fifo_rdy;
  wire       set_ri;
  wire       set_fe;
  wire [3:0] nbits;
  wire       mid;
  wire [7:0] rx_byte;
  wire       ninth;
  wire       stop_ok;
  wire       accept;
  wire       mp_on;           // filtering active
  wire       at_last;         // centre of last data bit
  wire       at_stop;         // centre of stop bit
  wire       stop_late;       // done waits for the stop bit
  wire       done_ev;         // frame finished
  wire [8:0] last_bit;        // last data bit in its slot
  wire [8:0] word;            // frame word, last bit folded in

  assign mode = {mode0_q, mode1_q};
  assign fes  = power_control_reg_q[`UFC_PC_BIT_FES];

  // ****************************************
  // address match functions
  // ****************************************
  // individual: masked bits must equal
  function match_ind;
    input [7:0] a;
    input [7:0] m;
    input [7:0] r;
    begin
      match_ind = (((r ^ a) & m) == 8'h00);
    end
  endfunction

  // broadcast: ones of a|m must be ones
  function match_bc;
    input [7:0] a;
    input [7:0] m;
    input [7:0] r;
    begin
      match_bc = (((a | m) & ~r) == 8'h00);
    end
  endfunction

  // ****************************************
  // line synchroniser
  // ****************************************
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_q <= 3'h7;
      line_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], rxd_i};
      // change counted once stages two and three agree
      if (sync_q[1] == sync_q[2]) begin
        line_q <= sync_q[2];
      end
    end
  end

  // ****************************************
  // receive framing
  // ****************************************
  // data bits: 8 in mode 1, 9 in modes 2 and 3
  assign nbits   = (mode == `UFC_MODE_UART8) ? 4'h8 : 4'h9;
  assign mid      = rx_tick_i & (ovs_q == `UFC_OVS_MID);
  assign at_last  = (state_q == ST_DATA) & mid & (bit_q == nbits - 4'h1);
  assign at_stop  = (state_q == ST_STOP) & mid;
  // the last data bit lands one edge late, so fold it in here
  assign last_bit = {8'h00, line_q} << bit_q;
  assign word     = shift_q | (at_last ? last_bit : 9'h000);
  assign rx_byte  = word[7:0];
  // mode 1: stop bit stands as ninth; not yet seen at last data bit, idle level taken
  assign ninth    = (mode == `UFC_MODE_UART8) ? (at_stop ? line_q : 1'b1) : word[8];
  assign stop_ok  = line_q;
  assign mp_on    = mp_q & (mode != `UFC_MODE_SHIFT);

  // decide whether the finished frame raises the done flag
  assign accept =
    !mp_on ? 1'b1 :
    (mode == `UFC_MODE_UART8) ?
      (ninth & stop_ok &
       (match_ind(node_address_byte_o, node_address_mask_o, rx_byte) |
        match_bc(node_address_byte_o, node_address_mask_o, rx_byte))) :
      (ninth &
       (match_ind(node_address_byte_o, node_address_mask_o, rx_byte) |
        match_bc(node_address_byte_o, node_address_mask_o, rx_byte)));

  // done fires at stop centre when checking, else at last data bit;
  // mode 1 filtering also waits for the stop, its ninth bit
  assign stop_late = fes | (mp_on & (mode == `UFC_MODE_UART8));
  assign done_ev   = stop_late ? at_stop : at_last;
  assign set_ri = done_ev & accept & fifo_rdy;
  assign set_fe = at_stop & fes & ~stop_ok;

  // receive state machine (shift mode is not received here)
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      ovs_q   <= 4'h0;
      bit_q   <= 4'h0;
      shift_q <= 9'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // start on falling line when enabled in async mode
          if (rx_tick_i && !line_q && ren_q && mode != `UFC_MODE_SHIFT) begin
            state_q <= ST_START;
            ovs_q   <= 4'h0;
          end
        end
        ST_START: begin
          if (rx_tick_i) begin
            ovs_q <= ovs_q + 4'h1;
          end
          if (mid) begin
            // false start rejected at bit centre
            state_q <= line_q ? ST_IDLE : ST_DATA;
            bit_q   <= 4'h0;
            shift_q <= 9'h000;
          end
        end
        ST_DATA: begin
          if (rx_tick_i) begin
            ovs_q <= ovs_q + 4'h1;
          end
          if (mid) begin
            // shift in lsb first, landing bit in its slot
            shift_q[bit_q] <= line_q;
            bit_q          <= bit_q + 4'h1;
            if (bit_q == nbits - 4'h1) begin
              state_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (rx_tick_i) begin
            ovs_q <= ovs_q + 4'h1;
          end
          if (mid) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // control registers and flags
  // ****************************************
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode0_q             <= 1'b0;
      mode1_q             <= 1'b0;
      mp_q                <= 1'b0;
      ren_q               <= 1'b0;
      tb8_q               <= 1'b0;
      rb8_q               <= 1'b0;
      ti_q                <= 1'b0;
      ri_q                <= 1'b0;
      fe_q                <= 1'b0;
      power_control_reg_q              <= 8'h00;
      node_address_byte_o <= `UFC_RST_ADDR;
      node_address_mask_o <= `UFC_RST_MASK;
      push_q              <= 1'b0;
      push_data_q         <= 9'h000;
    end else begin
      push_q <= 1'b0;
      if (power_control_reg_wr_i) begin
        power_control_reg_q <= power_control_reg_wdata_i;
      end
      if (addr_wr_i) begin
        node_address_byte_o <= reg_wdata_i;
      end
      if (mask_wr_i) begin
        node_address_mask_o <= reg_wdata_i;
      end
      if (serial_control_reg_wr_i) begin
        // bit 7 routes to error flag or mode bit
        if (fes) begin
          fe_q <= serial_control_reg_wdata_i[`UFC_SC_BIT_FE_M0];
        end else begin
          mode0_q <= serial_control_reg_wdata_i[`UFC_SC_BIT_FE_M0];
        end
        mode1_q <= serial_control_reg_wdata_i[`UFC_SC_BIT_M1];
        mp_q    <= serial_control_reg_wdata_i[`UFC_SC_BIT_MP];
        ren_q   <= serial_control_reg_wdata_i[`UFC_SC_BIT_REN];
        tb8_q   <= serial_control_reg_wdata_i[`UFC_SC_BIT_TB8];
        rb8_q   <= serial_control_reg_wdata_i[`UFC_SC_BIT_RB8];
        ti_q    <= serial_control_reg_wdata_i[`UFC_SC_BIT_TI];
        ri_q    <= serial_control_reg_wdata_i[`UFC_SC_BIT_RI];
      end
      // hardware sets win over software clears
      if (set_fe) begin
        fe_q <= 1'b1;
      end
      if (set_ri) begin
        ri_q        <= 1'b1;
        rb8_q       <= ninth;
        push_q      <= 1'b1;
        push_data_q <= {ninth, rx_byte};
      end
    end
  end

  // ****************************************
  // outputs and fifo
  // ****************************************
  assign serial_control_reg_o = {(fes ? fe_q : mode0_q), mode1_q, mp_q, ren_q,
                                 tb8_q, rb8_q, ti_q, ri_q};
  assign power_control_reg_o  = power_control_reg_q;
  assign frame_error_flag_o   = fe_q;
  assign receive_done_flag_o  = ri_q;

  ufc_fifo #(
    .W  (`UFC_FIFO_W),
    .D  (`UFC_FIFO_D),
    .AW (`UFC_FIFO_AW)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (push_data_q),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );
endmodule
`default_nettype wire

// ==== sim/uart_frame_check_addr_match_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// receive bench
// ****************
module uart_frame_check_addr_match_tb;
  logic            clock_i = 1'b0;
  logic            reset_n_i = 1'b0;
  logic [3:0]      wr_s = 4'h0;    // serial_control_reg, power_control_reg, addr, mask strobes
  logic [7:0]      wdata = 8'h00;
  logic            rx_ready = 1'b0;
  wire logic       rxd, tick, fe, ri, rv;
  wire logic [7:0] scr, pcr, nab, nam;
  wire logic [8:0] rd;
  int              miscompares = 0;
  int              n_compared = 0;
  int              cyc = 0;
  always #5 clock_i = ~clock_i;
  ufc_line_model i_ufc_line_model (.clock_i, .tick_o(tick), .rxd_o(rxd));
  ufc_rx i_ufc_rx (.clock_i, .reset_n_i, .rxd_i(rxd), .rx_tick_i(tick), .serial_control_reg_wr_i(wr_s[0]),
    .serial_control_reg_wdata_i(wdata), .power_control_reg_wr_i(wr_s[1]), .power_control_reg_wdata_i(wdata), .addr_wr_i(wr_s[2]),
    .mask_wr_i(wr_s[3]), .reg_wdata_i(wdata), .serial_control_reg_o(scr), .power_control_reg_o(pcr),
    .node_address_byte_o(nab), .node_address_mask_o(nam), .frame_error_flag_o(fe),
    .receive_done_flag_o(ri), .rx_valid_o(rv), .rx_ready_i(rx_ready), .rx_data_o(rd));
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one-cycle software write, s picks the strobe
  task automatic wr(input int s, input logic [7:0] v);
    @(negedge clock_i);
    wr_s[s] = 1'b1;
    wdata = v;
    @(negedge clock_i);
    wr_s = 4'h0;
  endtask
  task automatic frame(input logic [8:0] d, input int n, input logic s);
    i_ufc_line_model.send(d, n, s);
    repeat (4) @(negedge clock_i);
  endtask
  // head word checked, then taken
  task automatic pop(input logic [8:0] e);
    cmp("rx_valid", 9'h001, {8'h00, rv});
    cmp("rx_data", e, rd);
    rx_ready = 1'b1;
    @(negedge clock_i);
    rx_ready = 1'b0;
    // let an edge pass before the next pop raises ready again
    @(negedge clock_i);
  endtask
  task automatic flush();
    rx_ready = 1'b1;
    repeat (9) @(negedge clock_i);
    rx_ready = 1'b0;
  endtask
  task automatic t_reset();
    cmp("addr", 9'h000, {1'b0, nab});
    cmp("mask", 9'h000, {1'b0, nam});
    cmp("serial_control_reg", 9'h000, {1'b0, scr});
    cmp("power_control_reg", 9'h000, {1'b0, pcr});
  endtask
  // done flag moves one bit later with checking on
  task automatic t_timing();
    int c[2];
    for (int k = 0; k < 2; k++) begin
      wr(1, {1'b0, k[0], 6'h00});
      wr(0, 8'h50);
      c[k] = 0;
      // start on a fixed tick phase so both runs line up
      if (tick) @(negedge clock_i);
      fork
        i_ufc_line_model.send(9'h0A5, 8, 1'b1);
        while (ri !== 1'b1) begin
          @(negedge clock_i);
          c[k]++;
        end
      join
      repeat (4) @(negedge clock_i);
      pop(9'h1A5);
    end
    cmp("done_delay", 9'd32, 9'(c[1] - c[0]));
  endtask
  task automatic t_ferr();
    frame(9'h03C, 8, 1'b0);
    cmp("fe_set", 9'h001, {8'h00, fe});
    cmp("serial_control_reg_b7", 9'h001, {8'h00, scr[7]});
    flush();
    frame(9'h0C3, 8, 1'b1);
    cmp("fe_kept", 9'h001, {8'h00, fe});
    flush();
    wr(0, 8'h50);
    cmp("fe_clr", 9'h000, {8'h00, fe});
    wr(1, 8'h00);
  endtask
  // {expected, ninth, byte} against given 0101 01xx, broadcast 1111 111x
  task automatic t_filter();
    logic [9:0] ft[7] = '{10'h355, 10'h357, 10'h15E, 10'h3FE, 10'h3FF, 10'h17E, 10'h056};
    logic [7:0] md[3] = '{8'hF0, 8'hB0, 8'h70};
    wr(2, 8'h56);
    wr(3, 8'hFC);
    foreach (md[j]) begin
      wr(0, md[j]);
      foreach (ft[i]) begin
        frame(ft[i][8:0], (j == 2) ? 8 : 9, (j == 2) ? ft[i][8] : 1'b1);
        cmp("addr_hit", {8'h00, ft[i][9]}, {8'h00, ri});
        if (ft[i][9])
          pop({1'b1, ft[i][7:0]});
        wr(0, md[j]);
      end
    end
    // all-ones mask: only the exact address or the all-ones broadcast
    wr(3, 8'hFF);
    frame(9'h156, 8, 1'b1);
    cmp("exact_hit", 9'h001, {8'h00, ri});
    pop(9'h156);
    wr(0, 8'h70);
    frame(9'h157, 8, 1'b1);
    cmp("exact_miss", 9'h000, {8'h00, ri});
    cmp("fe_off", 9'h000, {8'h00, fe});
  endtask
  task automatic t_mode0();
    wr(0, 8'h30);
    frame(9'h155, 9, 1'b1);
    cmp("mode0_done", 9'h000, {8'h00, ri});
    cmp("mode0_push", 9'h000, {8'h00, rv});
  endtask
  // fill with the reader stalled, ninth frame refused, then drain
  task automatic t_fifo();
    for (int i = 0; i < 9; i++) begin
      wr(0, 8'h50);
      frame({1'b1, 8'(i + 16)}, 8, 1'b1);
      cmp("fill_done", {8'h00, i < 8}, {8'h00, ri});
    end
    for (int i = 0; i < 8; i++)
      pop({1'b1, 8'(i + 16)});
    cmp("drained", 9'h000, {8'h00, rv});
  endtask
  task automatic tally_and_finish();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    reset_n_i = 1'b1;
    t_reset();
    t_timing();
    t_ferr();
    t_filter();
    t_mode0();
    t_fifo();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== sim/ufc_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// far-end sender
// ****************
module ufc_line_model (
  // clock
  input  wire logic clock_i,
  // sample tick and serial line
  output var  logic tick_o,
  output var  logic rxd_o
);
  initial tick_o = 1'b0;
  // line idles high between frames
  initial rxd_o = 1'b1;
  // baud source: one tick every second cycle
  always @(negedge clock_i) begin
    tick_o <= ~tick_o;
  end
  // one frame lsb first: start, n data bits, stop; 16 ticks a bit
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    for (int i = 0; i < n + 2; i++) begin
      rxd_o = (i == 0) ? 1'b0 : (i > n) ? stp : d[i - 1];
      repeat (32) @(negedge clock_i);
    end
    rxd_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== sim/ufc_rx_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// receive checks
// ****************
module ufc_rx_chk (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  // software side
  input wire logic       serial_control_reg_wr_i,
  input wire logic       addr_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] serial_control_reg_o,
  input wire logic [7:0] power_control_reg_o,
  input wire logic [7:0] node_address_byte_o,
  input wire logic [7:0] node_address_mask_o,
  input wire logic       frame_error_flag_o,
  input wire logic       receive_done_flag_o,
  // stream
  input wire logic       rx_valid_o,
  input wire logic [8:0] rx_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // head byte hits given or broadcast address
  wire logic hit = ((((rx_data_o[7:0] ^ node_address_byte_o) & node_address_mask_o) == 8'h00) ||
                    (((node_address_byte_o | node_address_mask_o) & ~rx_data_o[7:0]) == 8'h00));
  // done flag raised by the receiver, not by software
  sequence s_hw_done;
    $rose(receive_done_flag_o) && !$past(serial_control_reg_wr_i);
  endsequence
  chk_fe_sticky: assert property (frame_error_flag_o && !(serial_control_reg_wr_i && power_control_reg_o[6]) |=>
    frame_error_flag_o) else $error("frame error dropped");
  chk_fe_needs_sel: assert property ($rose(frame_error_flag_o) |-> $past(power_control_reg_o[6]))
    else $error("frame error without select");
  chk_bit7_view: assert property (power_control_reg_o[6] |-> serial_control_reg_o[7] == frame_error_flag_o)
    else $error("bit 7 not frame error");
  chk_mode0_quiet: assert property (s_hw_done |-> $past(power_control_reg_o[6]) ||
    ($past(serial_control_reg_o[7:6]) != 2'h0)) else $error("done in shift mode");
  chk_done_push: assert property (s_hw_done |=> rx_valid_o) else $error("done without data");
  chk_addr_filter: assert property (s_hw_done ##0 serial_control_reg_o[5] && !rx_valid_o
    |=> rx_data_o[8] && hit) else $error("unmatched address taken");
  chk_addr_reset: assert property ($rose(reset_n_i) |-> node_address_byte_o == 8'h00 &&
    node_address_mask_o == 8'h00) else $error("address not cleared");
  chk_addr_load: assert property (addr_wr_i |=> node_address_byte_o == $past(reg_wdata_i))
    else $error("address not loaded");
endmodule
bind ufc_rx ufc_rx_chk i_ufc_rx_chk (.clock_i, .reset_n_i, .serial_control_reg_wr_i, .addr_wr_i, .reg_wdata_i,
  .serial_control_reg_o, .power_control_reg_o, .node_address_byte_o, .node_address_mask_o,
  .frame_error_flag_o, .receive_done_flag_o, .rx_valid_o, .rx_data_o);
`default_nettype wire
